// >>> bscc_pkg.sv
// Package of constants and types for the boost switching clock control block
`default_nettype none
package bscc_pkg;
   // ****************************************************
   // Timing base
   // ****************************************************
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned CLK_NS = 20;
   // Sync limits in kHz, and edge-loss timeout beyond the slowest sync period
   localparam int unsigned SYNC_MIN_KHZ = 300;
   localparam int unsigned SYNC_MAX_KHZ = 2200;
   localparam int unsigned SYNC_TMO_NS = 4000;
   localparam int unsigned SYNC_TMO_CYC = SYNC_TMO_NS / CLK_NS;
   // Static high must stand this long before spread spectrum comes on
   localparam int unsigned SS_WAIT_US = 256;
   localparam int unsigned SS_WAIT_CYC = SS_WAIT_US * (CLK_HZ / 1000000);
   // Spread modulation: 1 kHz triangle, +/-3 percent
   localparam int unsigned SS_MOD_HZ = 1000;
   localparam int unsigned SS_MOD_CYC = CLK_HZ / SS_MOD_HZ;
   localparam int unsigned SS_DEV_PCT = 3;
   // Current limit window, 1.5 s for each of the raised and rest phases
   localparam int unsigned ILIM_WIN_MS = 1500;
   localparam int unsigned ILIM_WIN_CYC = ILIM_WIN_MS * (CLK_HZ / 1000);
   // Current limits in mA
   localparam logic [11:0] ILIM_NORM_MA = 12'h7d0;
   localparam logic [11:0] ILIM_HIGH_MA = 12'h9c4;
   // Frequency range boundaries in kHz
   localparam logic [11:0] RANGE_B1_KHZ = 12'h1e0;
   localparam logic [11:0] RANGE_B2_KHZ = 12'h47e;
   localparam logic [11:0] RANGE_B3_KHZ = 12'h672;
   // Adaptive target code: 256 steps, initial 0.88 of span (225/256)
   localparam logic [8:0] VT_MAX = 9'h100;
   localparam logic [8:0] VT_INIT = 9'h0e1;
   // Sync mode states
   typedef enum logic [2:0] {
      BSCC_ST_LOW = 3'b001,
      BSCC_ST_HIGH = 3'b010,
      BSCC_ST_EXT = 3'b100
   } bscc_mode_t;
   // Current limit phases
   typedef enum logic [2:0] {
      BSCC_IL_NORM = 3'b001,
      BSCC_IL_RAISED = 3'b010,
      BSCC_IL_REST = 3'b100
   } bscc_ilim_t;
endpackage
`default_nettype wire

// >>> bscc_sync_src.sv
// Sync pin source model: toggling clock or static level
`default_nettype none
module bscc_sync_src #(
   parameter int HALF_NS = 80
) (
   input wire logic i_run,
   input wire logic i_rest,
   output logic o_sync
);
   timeunit 1ns;
   timeprecision 1ns;
   // Clock only while running, otherwise parked at the commanded level
   initial begin
      o_sync = 1'b0;
      forever begin
         if (i_run) begin
            #HALF_NS o_sync = ~o_sync;
         end else begin
            #1 o_sync = i_rest;
         end
      end
   end
endmodule
`default_nettype wire

// >>> bscc_top.sv
// Switching clock, spread spectrum, current limit and voltage target control
`default_nettype none
module bscc_top
   import bscc_pkg::*;
#(
   parameter int unsigned WAIT_CYC = SS_WAIT_CYC,
   parameter int unsigned WIN_CYC = ILIM_WIN_CYC,
   parameter int unsigned MOD_CYC = SS_MOD_CYC
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_io_supply_enable_pin,
   input wire logic i_sync_pin,
   input wire logic [11:0] i_freq_resistor_pin_khz,
   input wire logic i_ilim_hit,
   input wire logic i_ovp48,
   input wire logic i_vt_up,
   input wire logic i_vt_down,
   output logic o_enable,
   output logic o_ext_sync,
   output logic o_sync_clk,
   output logic o_ss_enable,
   output logic signed [7:0] o_ss_offset,
   output logic [1:0] o_range,
   output logic [11:0] o_ilim_ma,
   output logic o_switch_allow,
   output logic [8:0] o_vt_code
);
   // ****************************************************
   // Input synchronisers
   // ****************************************************
   logic [1:0] en_s_r, sy_s_r, ov_s_r;
   logic sy_d_r;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         en_s_r <= 2'h0;
         sy_s_r <= 2'h0;
         ov_s_r <= 2'h0;
         sy_d_r <= 1'b0;
      end else begin
         en_s_r <= {en_s_r[0], i_io_supply_enable_pin};
         sy_s_r <= {sy_s_r[0], i_sync_pin};
         ov_s_r <= {ov_s_r[0], i_ovp48};
         sy_d_r <= sy_s_r[1];
      end
   end
   wire logic en_w = en_s_r[1];
   wire logic sy_w = sy_s_r[1];
   wire logic edge_w = sy_w ^ sy_d_r;

   // ****************************************************
   // Sync mode detection
   // ****************************************************
   // Needs two edges before declaring a clock, so a single step is a level
   bscc_mode_t mode_r;
   logic [15:0] tmo_r;
   logic [23:0] hi_cnt_r;
   logic edge_seen_r;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !en_w) begin
         mode_r <= BSCC_ST_LOW;
         tmo_r <= 16'h0;
         edge_seen_r <= 1'b0;
      end else if (edge_w) begin
         tmo_r <= 16'h0;
         edge_seen_r <= 1'b1;
         if (edge_seen_r) mode_r <= BSCC_ST_EXT;
      end else if (tmo_r < 16'(SYNC_TMO_CYC)) begin
         tmo_r <= tmo_r + 16'h1;
      end else begin
         edge_seen_r <= 1'b0;
         if (!sy_w) mode_r <= BSCC_ST_LOW;
         else if (hi_cnt_r >= 24'(WAIT_CYC)) mode_r <= BSCC_ST_HIGH;
         // Lost clock with the pin high runs unspread until the dwell ends
         else mode_r <= BSCC_ST_LOW;
      end
   end
   // High-level dwell counter for the delayed spread start
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !sy_w || edge_w) hi_cnt_r <= 24'h0;
      else if (hi_cnt_r < 24'(WAIT_CYC)) hi_cnt_r <= hi_cnt_r + 24'h1;
   end

   // ****************************************************
   // Outputs of mode logic
   // ****************************************************
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_enable <= 1'b0;
         o_ext_sync <= 1'b0;
         o_sync_clk <= 1'b0;
         o_ss_enable <= 1'b0;
      end else begin
         o_enable <= en_w;
         o_ext_sync <= en_w && mode_r == BSCC_ST_EXT;
         o_sync_clk <= sy_w;
         o_ss_enable <= en_w && mode_r == BSCC_ST_HIGH;
      end
   end

   // ****************************************************
   // Spread modulation: triangle over +/-SS_DEV_PCT*10 permille
   // ****************************************************
   localparam int unsigned QTR = MOD_CYC / 120;
   // Signed turn point, so negative offsets never look large
   localparam logic signed [7:0] SS_TOP = 8'(SS_DEV_PCT * 10 - 1);
   logic [15:0] ss_div_r;
   logic ss_dir_r;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !o_ss_enable) begin
         ss_div_r <= 16'h0;
         ss_dir_r <= 1'b1;
         o_ss_offset <= 8'sh0;
      end else if (ss_div_r >= 16'(QTR - 1)) begin
         ss_div_r <= 16'h0;
         if (ss_dir_r) begin
            if (o_ss_offset >= SS_TOP) ss_dir_r <= 1'b0;
            o_ss_offset <= o_ss_offset + 8'sh1;
         end else begin
            if (o_ss_offset <= -SS_TOP) ss_dir_r <= 1'b1;
            o_ss_offset <= o_ss_offset - 8'sh1;
         end
      end else begin
         ss_div_r <= ss_div_r + 16'h1;
      end
   end

   // ****************************************************
   // Range selection from resistor frequency
   // ****************************************************
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) o_range <= 2'h0;
      else if (i_freq_resistor_pin_khz < RANGE_B1_KHZ) o_range <= 2'h0;
      else if (i_freq_resistor_pin_khz < RANGE_B2_KHZ) o_range <= 2'h1;
      else if (i_freq_resistor_pin_khz < RANGE_B3_KHZ) o_range <= 2'h2;
      else o_range <= 2'h3;
   end

   // ****************************************************
   // Current limit sequencing
   // ****************************************************
   // Rest phase holds the normal limit so sustained overload toggles every 1.5 s
   bscc_ilim_t il_r;
   logic [31:0] il_cnt_r;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !en_w) begin
         il_r <= BSCC_IL_NORM;
         il_cnt_r <= 32'h0;
      end else begin
         case (il_r)
            BSCC_IL_NORM: begin
               il_cnt_r <= 32'h0;
               if (i_ilim_hit) il_r <= BSCC_IL_RAISED;
            end
            BSCC_IL_RAISED: begin
               if (il_cnt_r >= 32'(WIN_CYC - 1)) begin
                  il_cnt_r <= 32'h0;
                  il_r <= BSCC_IL_REST;
               end else il_cnt_r <= il_cnt_r + 32'h1;
            end
            BSCC_IL_REST: begin
               if (il_cnt_r >= 32'(WIN_CYC - 1)) begin
                  il_cnt_r <= 32'h0;
                  il_r <= BSCC_IL_NORM;
               end else il_cnt_r <= il_cnt_r + 32'h1;
            end
            default: il_r <= BSCC_IL_NORM;
         endcase
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) o_ilim_ma <= ILIM_NORM_MA;
      else o_ilim_ma <= (il_r == BSCC_IL_RAISED) ? ILIM_HIGH_MA : ILIM_NORM_MA;
   end

   // ****************************************************
   // Overvoltage gate and adaptive target
   // ****************************************************
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) o_switch_allow <= 1'b0;
      else o_switch_allow <= en_w && !ov_s_r[1];
   end
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !en_w) o_vt_code <= VT_INIT;
      else if (i_vt_up && !i_vt_down && o_vt_code < VT_MAX) o_vt_code <= o_vt_code + 9'h1;
      else if (i_vt_down && !i_vt_up && o_vt_code != 9'h0) o_vt_code <= o_vt_code - 9'h1;
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   no_ss_ext_a: assert property (!(o_ext_sync && o_ss_enable))
      else $error("spread on in external sync");
   low_no_ss_a: assert property (mode_r == BSCC_ST_LOW |=> !o_ss_enable)
      else $error("spread on while low");
   ss_wait_a: assert property ($rose(mode_r == BSCC_ST_HIGH) |-> hi_cnt_r >= 24'(WAIT_CYC))
      else $error("spread before wait");
   ss_span_a: assert property (o_ss_offset <= 8'sd30 && o_ss_offset >= -8'sd30)
      else $error("spread out of span");
   ilim_val_a: assert property (il_r == BSCC_IL_RAISED |=> o_ilim_ma == ILIM_HIGH_MA)
      else $error("raised limit missing");
   ilim_rest_a: assert property ($fell(il_r == BSCC_IL_RAISED) && en_w |-> il_r == BSCC_IL_REST)
      else $error("no rest after raised");
   ovp_gate_a: assert property (ov_s_r[1] |=> !o_switch_allow)
      else $error("switching during ovp");
   vt_bound_a: assert property (o_vt_code <= VT_MAX)
      else $error("target out of span");
   vt_step_a: assert property (en_w && $past(en_w) |-> o_vt_code - $past(o_vt_code) <= 9'h1
      || $past(o_vt_code) - o_vt_code <= 9'h1)
      else $error("target step too big");
   ext_loss_a: assert property (tmo_r == 16'(SYNC_TMO_CYC) && !edge_w |=> mode_r != BSCC_ST_EXT)
      else $error("external mode kept after loss");
   ext_c: cover property (o_ext_sync ##1 !o_ext_sync);
   ss_c: cover property (o_ss_enable && o_ss_offset == 8'sd30);
   il_c: cover property (il_r == BSCC_IL_REST);
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the switching clock control block
`default_nettype none
module tb;
   import bscc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WAIT = 400;
   localparam int WIN = 100;
   localparam int MOD = 1200;
   logic i_clock = 1'b0, i_sys_rst = 1'b1, en = 1'b0, hit = 1'b0, ovp = 1'b0;
   logic up = 1'b0, dn = 1'b0, run = 1'b0, rest = 1'b0, sync;
   logic [11:0] freq_resistor_pin = 12'h12c;
   logic ena, ext, ss, allow, sclk, sp;
   logic signed [7:0] ofs, lo, hi;
   logic [1:0] rng;
   logic [11:0] ilim;
   logic [8:0] vt;
   int error_cnt = 0, total_checks = 0, n, m, p0, p1;
   bscc_sync_src src (.i_run(run), .i_rest(rest), .o_sync(sync));
   bscc_top #(.WAIT_CYC(WAIT), .WIN_CYC(WIN), .MOD_CYC(MOD)) uut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_io_supply_enable_pin(en),
      .i_sync_pin(sync), .i_freq_resistor_pin_khz(freq_resistor_pin), .i_ilim_hit(hit), .i_ovp48(ovp),
      .i_vt_up(up), .i_vt_down(dn), .o_enable(ena), .o_ext_sync(ext), .o_sync_clk(sclk),
      .o_ss_enable(ss), .o_ss_offset(ofs), .o_range(rng), .o_ilim_ma(ilim),
      .o_switch_allow(allow), .o_vt_code(vt));
   // ****************************************************
   // Clock and helpers
   // ****************************************************
   initial begin
      forever #10 i_clock = ~i_clock;
   end
   // Drive just after the edge so the design samples settled inputs
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clock);
      #2;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return ext;
         1: return ss;
         2: return ena;
         default: return ilim === ILIM_HIGH_MA;
      endcase
   endfunction
   // Bounded wait; running out ends the run as a mismatch
   task automatic wait_lvl(input int s, input logic lvl, input int lim, output int k);
      k = 0;
      while (pick(s) !== lvl && k < lim) begin
         cyc(1);
         k++;
      end
      if (pick(s) !== lvl) begin
         error_cnt++;
         $display("[FAIL] %0t timeout on signal %0d", $time, s);
         complete_run();
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_reset();
      cyc(6);
      check(12'(ena), 12'h001);
      check(ilim, ILIM_NORM_MA);
      check(12'(vt), 12'(VT_INIT));
      check(12'({ext, ss}), 12'h000);
      check(12'(allow), 12'h001);
      $display("reset done");
   endtask
   // Static high must hold the full wait before spread starts
   task automatic t_high();
      rest = 1'b1;
      wait_lvl(1, 1'b1, WAIT + 50, n);
      check(12'(n >= WAIT - 4 && n <= WAIT + 10), 12'h001);
      lo = 8'sh00;
      hi = 8'sh00;
      m = 0;
      p0 = 0;
      p1 = 0;
      // Two arrivals at the top one modulation period apart
      for (int i = 1; i <= 2 * MOD; i++) begin
         cyc(1);
         if (ofs > hi) hi = ofs;
         if (ofs < lo) lo = ofs;
         if (ofs == 8'sd30 && m != 30) begin
            if (p0 == 0) p0 = i;
            else if (p1 == 0) p1 = i;
         end
         m = ofs;
      end
      check(12'(p1 - p0), 12'(MOD));
      check(12'(hi), 12'(30));
      check(12'(lo), 12'(-30));
      $display("static high done");
   endtask
   task automatic t_ext();
      run = 1'b1;
      wait_lvl(0, 1'b1, 60, n);
      cyc(300);
      check(12'({ext, ss}), 12'h002);
      // Followed clock toggles every 4 cycles of the 160 ns source
      sp = sclk;
      m = 0;
      repeat (32) begin
         cyc(1);
         if (sclk !== sp) m++;
         sp = sclk;
      end
      check(12'(m), 12'h008);
      $display("external sync done");
   endtask
   // Clock loss with the pin resting at lvl
   task automatic t_stop(input logic lvl);
      rest = lvl;
      run = 1'b0;
      if (lvl) begin
         wait_lvl(0, 1'b0, SYNC_TMO_CYC + 20, n);
         check(12'(n >= SYNC_TMO_CYC - 4 && ss === 1'b0), 12'h001);
         wait_lvl(1, 1'b1, WAIT + 20, m);
         check(12'(n + m >= WAIT - 4), 12'h001);
         check(12'({ext, allow}), 12'h001);
      end else begin
         wait_lvl(0, 1'b0, SYNC_TMO_CYC + 20, n);
         check(12'(n >= SYNC_TMO_CYC - 4), 12'h001);
         check(12'(ss), 12'h000);
         cyc(3);
         check(12'({ss, allow}), 12'h001);
      end
      $display("clock loss done");
   endtask
   task automatic t_range();
      logic [11:0] f[6] = '{12'h1df, 12'h1e0, 12'h47d, 12'h47e, 12'h671, 12'h672};
      logic [1:0] r[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
      for (int i = 0; i < 6; i++) begin
         freq_resistor_pin = f[i];
         cyc(4);
         check(12'(rng), 12'(r[i]));
      end
      $display("range done");
   endtask
   task automatic t_ilim();
      hit = 1'b1;
      wait_lvl(3, 1'b1, 6, n);
      wait_lvl(3, 1'b0, WIN + 10, n);
      check(12'(n >= WIN - 3 && n <= WIN + 3), 12'h001);
      wait_lvl(3, 1'b1, WIN + 10, n);
      check(12'(n >= WIN - 3 && n <= WIN + 3), 12'h001);
      hit = 1'b0;
      $display("current limit done");
   endtask
   task automatic t_vt();
      dn = 1'b1;
      cyc(240);
      dn = 1'b0;
      cyc(3);
      check(12'(vt), 12'h000);
      up = 1'b1;
      cyc(1);
      up = 1'b0;
      cyc(3);
      check(12'(vt), 12'h001);
      up = 1'b1;
      cyc(300);
      up = 1'b0;
      cyc(3);
      check(12'(vt), 12'(VT_MAX));
      $display("target done");
   endtask
   // Overvoltage, then disable returns to defaults
   task automatic t_ovp_off();
      ovp = 1'b1;
      cyc(5);
      check(12'(allow), 12'h000);
      ovp = 1'b0;
      en = 1'b0;
      wait_lvl(2, 1'b0, 8, n);
      cyc(WIN * 3);
      check(12'(allow), 12'h000);
      check(ilim, ILIM_NORM_MA);
      check(12'(vt), 12'(VT_INIT));
      $display("disable done");
   endtask
   initial begin
      cyc(10);
      i_sys_rst = 1'b0;
      en = 1'b1;
      t_reset();
      t_high();
      t_ext();
      t_stop(1'b1);
      t_ext();
      t_stop(1'b0);
      t_range();
      t_ilim();
      t_vt();
      t_ovp_off();
      complete_run();
   end
endmodule
`default_nettype wire
